// >>> src/cors_pkg.sv
/*
 * shared constants and types for the configuration options register and
 * reset-state block.
 * assumes a single 100 MHz clock that stands for the e-clock.
 */
`default_nettype none
package cors_pkg;
    localparam logic [15:0] CORS_OPT_OFFSET = 16'h1039;
    localparam logic [15:0] CORS_STAT_OFFSET = 16'h103A;
    localparam logic [7:0] CORS_OPT_RESET = 8'h10;
    localparam int CORS_BIT_ADC_POWER_UP = 7;
    localparam int CORS_BIT_ADC_CLOCK_SOURCE_SELECT = 6;
    localparam int CORS_BIT_EXT_INT_EDGE_ONLY = 5;
    localparam int CORS_BIT_DLY = 4;
    localparam int CORS_BIT_CME = 3;
    localparam int CORS_BIT_UNUSED = 2;
    localparam logic [7:0] CORS_ANYTIME_MASK = 8'hC8;
    localparam logic [7:0] CORS_ONCE_MASK = 8'h33;
    localparam int CORS_WINDOW_CYCLES = 64;
    localparam int CORS_STOP_DELAY_CYCLES = 4064;
    localparam int CORS_WDOG_PRE_LOG2 = 15;
    localparam logic [4:0] CORS_PRIO_RESET = 5'h06;
    localparam logic [15:0] CORS_VEC_NORMAL = 16'hFFFE;
    localparam logic [15:0] CORS_VEC_SPECIAL = 16'hBFFE;
    localparam logic [15:0] CORS_TIMER_RESET = 16'h0000;
    localparam logic [15:0] CORS_COMPARE_RESET = 16'hFFFF;
    localparam logic [15:0] CORS_ROM_BASE = 16'hC000;
    localparam logic [15:0] CORS_RAM_LAST = 16'h01FF;
    localparam logic [15:0] CORS_REG_BASE = 16'h1000;
    localparam logic [15:0] CORS_REG_LAST = 16'h107F;
    localparam logic [15:0] CORS_BOOT_BASE = 16'hBF00;
    localparam logic [15:0] CORS_BOOT_LAST = 16'hBFFF;
    localparam logic [15:0] CORS_VEC_AREA = 16'hFFC0;
    localparam int CORS_ADDR_A14 = 14;

    typedef enum logic [1:0] {
        CORS_MODE_BOOT,
        CORS_MODE_TEST,
        CORS_MODE_SINGLE,
        CORS_MODE_EXPANDED
    } cors_mode_t;

    typedef struct packed {
        logic rom_enable;
        logic watchdog_enable;
        logic boot_rom_enable;
        logic special_mode_flag;
        logic mode_a_latched;
        logic internal_read_visibility;
        logic fail_reset_disable;
        logic [4:0] priority_source_select;
        logic [2:0] condition_flags_sxi;
        logic [15:0] restart_vector;
    } cors_sys_t;

    typedef struct packed {
        logic [15:0] timer_count;
        logic [15:0] compare_value;
        logic [7:0] timer_flags_masks;
        logic [7:0] serial_status;
        logic [7:0] serial_control;
        logic [7:0] periodic_pulse_ctl;
        logic [7:0] port_c_direction;
        logic [7:0] port_bf_out;
        logic rw_out;
    } cors_periph_t;

    typedef struct packed {
        logic ram_sel;
        logic reg_sel;
        logic rom_sel;
        logic boot_sel;
        logic [15:0] eff_addr;
    } cors_decode_t;
endpackage : cors_pkg
`default_nettype wire

// >>> src/cors_top.sv
/*
 * configuration options register with write-once protection, stop-exit
 * delay, watchdog timebase, and the reset-time system state.
 * assumes mode pins and irq pin arrive asynchronously; cpu fetch address,
 * stop request and clock-fail level come from logic on mclk.
 */
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - adc power, adc clock, clock monitor bits writable any time.
// - normal modes: bits 0,1,4,5 written once, first 64 cycles only.
// - special mode: all writable bits writable any time.
// - adc power bit zero powers adc down, one powers up.
// - adc clock bit selects e-clock (0) or internal rc (1).
// - edge bit zero gives low-level irq, one gives falling edges.
// - delay bit set at reset; set means 4064-cycle stop-exit wait.
// - clock monitor bit one lets clock failure request a reset in normal modes.
// - watchdog tick is e-clock divided by two to the fifteenth.
// - rate field 00..11 adds divide by 1, 4, 16, 64.
// - rom on except expanded; watchdog on only single-chip, expanded.
// - restart vector at fffe normally, bffe in boot or test.
// - reset sets x, i and s condition flags.
// - decode rom c000-ffff, ram 0000-01ff, regs 1000-107f, boot rom.
// - boot and test modes force a14 low on vector fetch.
// - timer count 0000, compares ffff, timer flags and masks clear.
// - serial tx flags set, rx flags, enables and masks clear.
// - priority source select reset to 00110.
// - read visibility set in special mode, clear in normal.
// - fail-reset disable set in special mode, clear in normal.
// - boot rom, special and mode-a bits capture mode pins at reset.
// - port c input, ports b and f zero outputs, read/write high.
// - periodic interrupt and pulse accumulator controls cleared.
//////////////////////////////////////////////////////////////////////////////
module cors_top
    import cors_pkg::*;
#(
    parameter int STOP_DELAY = CORS_STOP_DELAY_CYCLES,
    parameter int WDOG_PRE_LOG2 = CORS_WDOG_PRE_LOG2
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic ext_int_pin_n,
    input wire logic [15:0] cpu_addr,
    input wire logic vector_fetch,
    input wire logic stop_req,
    input wire logic stop_wake,
    input wire logic clock_slow,
    output logic adc_power_up,
    output logic adc_clock_source_select,
    output logic ext_int_req,
    output logic cpu_hold,
    output logic clock_fail_reset,
    output logic watchdog_tick,
    output cors_sys_t sys_state,
    output cors_periph_t periph_state,
    output cors_decode_t decode
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    // no reset: the pins must already be settled when reset lifts
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            pin_s1_reg <= {ext_int_pin_n, mode_pin_b, mode_pin_a};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // mode capture one cycle after reset release, once the pins are settled
    logic captured_reg;
    logic mode_pin_a_reg;
    logic mode_pin_b_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            captured_reg <= 1'b0;
            mode_pin_a_reg <= 1'b0;
            mode_pin_b_reg <= 1'b0;
        end else if (clk_en && !captured_reg) begin
            captured_reg <= 1'b1;
            mode_pin_a_reg <= pin_s2_reg[0];
            mode_pin_b_reg <= pin_s2_reg[1];
        end
    end

    cors_mode_t mode;
    assign mode = cors_mode_t'({mode_pin_b_reg, mode_pin_a_reg});
    logic special;
    assign special = !mode_pin_b_reg;

    //////////////////////////////////////////////////////////////////////////
    // write window counter
    logic [6:0] win_cnt_reg;
    logic once_done_reg;
    logic win_open;
    assign win_open = win_cnt_reg < 7'(CORS_WINDOW_CYCLES);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            win_cnt_reg <= 7'h00;
        end else if (clk_en && win_open) begin
            win_cnt_reg <= win_cnt_reg + 7'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // options register
    logic opt_hit;
    logic stat_hit;
    logic [7:0] opt_reg;
    logic [7:0] opt_next;
    logic [7:0] wr_mask;
    assign opt_hit = reg_addr == CORS_OPT_OFFSET;
    assign stat_hit = reg_addr == CORS_STAT_OFFSET;
    always_comb begin
        wr_mask = CORS_ANYTIME_MASK;
        if (special || (win_open && !once_done_reg)) begin
            wr_mask = CORS_ANYTIME_MASK | CORS_ONCE_MASK;
        end
        opt_next = (opt_reg & ~wr_mask) | (reg_wdata & wr_mask);
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            opt_reg <= CORS_OPT_RESET;
        end else if (clk_en && reg_wr && opt_hit) begin
            opt_reg <= opt_next;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            once_done_reg <= 1'b0;
        end else if (clk_en && reg_wr && opt_hit && win_open) begin
            once_done_reg <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd && opt_hit) begin
                reg_rdata <= opt_reg;
            end else if (reg_rd && stat_hit) begin
                reg_rdata <= {1'b0, win_open, once_done_reg, cpu_hold,
                              special, mode_pin_b_reg, mode_pin_a_reg, captured_reg};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // adc controls
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adc_power_up <= 1'b0;
            adc_clock_source_select <= 1'b0;
        end else if (clk_en) begin
            adc_power_up <= opt_reg[CORS_BIT_ADC_POWER_UP];
            adc_clock_source_select <= opt_reg[CORS_BIT_ADC_CLOCK_SOURCE_SELECT];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // external interrupt: level or falling edge
    logic irq_prev_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_prev_reg <= 1'b1;
            ext_int_req <= 1'b0;
        end else if (clk_en) begin
            irq_prev_reg <= pin_s2_reg[2];
            if (opt_reg[CORS_BIT_EXT_INT_EDGE_ONLY]) begin
                ext_int_req <= irq_prev_reg && !pin_s2_reg[2];
            end else begin
                ext_int_req <= !pin_s2_reg[2];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // stop mode and exit delay; delay bit read as stop is left
    typedef enum logic [1:0] {CORS_RUN, CORS_STOPPED, CORS_WAKING} cors_stop_t;
    cors_stop_t stop_reg;
    logic [12:0] dly_cnt_reg;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stop_reg <= CORS_RUN;
            dly_cnt_reg <= 13'h0000;
            cpu_hold <= 1'b0;
        end else if (clk_en) begin
            unique case (stop_reg)
                CORS_RUN: begin
                    if (stop_req) begin
                        stop_reg <= CORS_STOPPED;
                        cpu_hold <= 1'b1;
                    end
                end
                CORS_STOPPED: begin
                    if (stop_wake && opt_reg[CORS_BIT_DLY]) begin
                        stop_reg <= CORS_WAKING;
                        dly_cnt_reg <= 13'(STOP_DELAY - 1);
                    end else if (stop_wake) begin
                        stop_reg <= CORS_RUN;
                        cpu_hold <= 1'b0;
                    end
                end
                CORS_WAKING: begin
                    if (dly_cnt_reg == 13'h0000) begin
                        stop_reg <= CORS_RUN;
                        cpu_hold <= 1'b0;
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - 13'h0001;
                    end
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // clock monitor: gated request, suppressed by fail-reset disable
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clock_fail_reset <= 1'b0;
        end else if (clk_en) begin
            clock_fail_reset <= opt_reg[CORS_BIT_CME] && clock_slow
                                && !sys_state.fail_reset_disable;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // watchdog timebase: 2^15 prescale then 1/4/16/64
    logic [WDOG_PRE_LOG2+5:0] wdog_cnt_reg;
    logic [WDOG_PRE_LOG2+5:0] wdog_last;
    always_comb begin
        unique case (opt_reg[1:0])
            2'h0: wdog_last = (WDOG_PRE_LOG2 + 6)'((1 << WDOG_PRE_LOG2) - 1);
            2'h1: wdog_last = (WDOG_PRE_LOG2 + 6)'((1 << (WDOG_PRE_LOG2 + 2)) - 1);
            2'h2: wdog_last = (WDOG_PRE_LOG2 + 6)'((1 << (WDOG_PRE_LOG2 + 4)) - 1);
            2'h3: wdog_last = (WDOG_PRE_LOG2 + 6)'((1 << (WDOG_PRE_LOG2 + 6)) - 1);
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wdog_cnt_reg <= '0;
            watchdog_tick <= 1'b0;
        end else if (clk_en) begin
            watchdog_tick <= 1'b0;
            if (!sys_state.watchdog_enable) begin
                wdog_cnt_reg <= '0;
            end else if (wdog_cnt_reg >= wdog_last) begin
                wdog_cnt_reg <= '0;
                watchdog_tick <= 1'b1;
            end else begin
                wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // mode-dependent system state, refreshed every cycle once the capture lands
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sys_state <= '0;
            sys_state.condition_flags_sxi <= 3'h7;
            sys_state.priority_source_select <= CORS_PRIO_RESET;
            sys_state.restart_vector <= CORS_VEC_NORMAL;
        end else if (clk_en && captured_reg) begin
            sys_state.rom_enable <= mode != CORS_MODE_EXPANDED;
            sys_state.watchdog_enable <= !special;
            sys_state.boot_rom_enable <= mode == CORS_MODE_BOOT;
            sys_state.special_mode_flag <= special;
            sys_state.mode_a_latched <= mode_pin_a_reg;
            sys_state.internal_read_visibility <= special;
            sys_state.fail_reset_disable <= special;
            sys_state.restart_vector <= special ? CORS_VEC_SPECIAL
                                                : CORS_VEC_NORMAL;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // peripheral reset values
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            periph_state.timer_count <= CORS_TIMER_RESET;
            periph_state.compare_value <= CORS_COMPARE_RESET;
            periph_state.timer_flags_masks <= 8'h00;
            periph_state.serial_status <= 8'hC0;
            periph_state.serial_control <= 8'h00;
            periph_state.periodic_pulse_ctl <= 8'h00;
            periph_state.port_c_direction <= 8'h00;
            periph_state.port_bf_out <= 8'h00;
            periph_state.rw_out <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // address decode and vector a14 forcing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            decode <= '0;
        end else if (clk_en) begin
            decode.eff_addr <= cpu_addr;
            if (vector_fetch && special && cpu_addr >= CORS_VEC_AREA) begin
                decode.eff_addr[CORS_ADDR_A14] <= 1'b0;
            end
            decode.ram_sel <= cpu_addr <= CORS_RAM_LAST;
            decode.reg_sel <= cpu_addr >= CORS_REG_BASE && cpu_addr <= CORS_REG_LAST;
            decode.rom_sel <= cpu_addr >= CORS_ROM_BASE && sys_state.rom_enable
                              && !(vector_fetch && special);
            decode.boot_sel <= sys_state.boot_rom_enable && ((cpu_addr >= CORS_BOOT_BASE
                               && cpu_addr <= CORS_BOOT_LAST)
                               || (vector_fetch && cpu_addr >= CORS_VEC_AREA));
        end
    end
endmodule : cors_top
`default_nettype wire

// >>> verif/cors_props.sv
/*
 * assertions on the ports of cors_top.
 * assumes the single clock mclk and the synchronous active-low rstn.
 */
`default_nettype none
module cors_props
    import cors_pkg::*;
#(
    parameter int STOP_DELAY = CORS_STOP_DELAY_CYCLES,
    parameter int WDOG_PRE_LOG2 = CORS_WDOG_PRE_LOG2
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] cpu_addr,
    input wire logic vector_fetch,
    input wire logic stop_req,
    input wire logic clock_slow,
    input wire logic adc_power_up,
    input wire logic cpu_hold,
    input wire logic clock_fail_reset,
    input wire logic watchdog_tick,
    input wire cors_sys_t sys_state,
    input wire cors_decode_t decode
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    wire opt_sel = clk_en && reg_addr == CORS_OPT_OFFSET;
    ////////////////////////////////////////////////////////////////
    a_bit2_zero: assert property (opt_sel && reg_rd |=> !reg_rdata[2])
        else $error("option bit 2 read back set");
    a_adc_power_copy: assert property (opt_sel && reg_wr ##1 clk_en
        |=> adc_power_up == $past(reg_wdata[7], 2)) else $error("adc power bit not applied");
    a_stop_hold: assert property (clk_en && stop_req |=> cpu_hold)
        else $error("stop request without hold");
    a_monitor_quiet: assert property (clk_en && !clock_slow |=> !clock_fail_reset)
        else $error("clock fail without slow clock");
    a_fail_masked: assert property (clk_en && sys_state.fail_reset_disable
        |=> !clock_fail_reset) else $error("clock fail while disabled");
    a_wdog_off: assert property (!sys_state.watchdog_enable |-> !watchdog_tick)
        else $error("watchdog tick while disabled");
    a_tick_pulse: assert property (clk_en && watchdog_tick |=> !watchdog_tick)
        else $error("watchdog tick longer than one cycle");
    a_vec_a14: assert property (clk_en && vector_fetch && cpu_addr >= CORS_VEC_AREA
        && sys_state.special_mode_flag |=> !decode.eff_addr[14])
        else $error("vector fetch not redirected");
    a_reset_state: assert property (disable iff (1'h0) !rstn |=>
        sys_state.priority_source_select == CORS_PRIO_RESET && sys_state.condition_flags_sxi == 3'h7)
        else $error("reset state wrong");
    c_opt_write: cover property (opt_sel && reg_wr);
    c_tick: cover property (watchdog_tick);
    c_hold_end: cover property ($fell(cpu_hold));
endmodule : cors_props

bind cors_top cors_props #(.STOP_DELAY(STOP_DELAY), .WDOG_PRE_LOG2(WDOG_PRE_LOG2)) cors_props_i (
    .mclk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr,
    .vector_fetch, .stop_req, .clock_slow, .adc_power_up, .cpu_hold, .clock_fail_reset,
    .watchdog_tick, .sys_state, .decode);
`default_nettype wire

// >>> verif/tb_top.sv
/*
 * directed scenarios for cors_top with shortened stop delay and prescaler.
 * assumes clk_en held high; mode pins steady across each reset.
 */
`default_nettype none
module tb_top
    import cors_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] OPT = CORS_OPT_OFFSET;
    logic mclk = 1'h0, rstn = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic mode_pin_a = 1'h0, mode_pin_b = 1'h1, ext_int_pin_n = 1'h1, vector_fetch = 1'h0;
    logic stop_req = 1'h0, stop_wake = 1'h0, clock_slow = 1'h0;
    logic [15:0] reg_addr = 16'h0, cpu_addr = 16'h0;
    logic [7:0] reg_wdata = 8'h0, reg_rdata;
    logic adc_power_up, adc_clock_source_select, ext_int_req, cpu_hold, clock_fail_reset;
    logic watchdog_tick;
    cors_sys_t sys_state;
    cors_periph_t periph_state;
    cors_decode_t decode;
    int failures = 0, compares = 0;

    always #5 mclk = ~mclk;

    // small counts keep the run short
    cors_top #(.STOP_DELAY(8), .WDOG_PRE_LOG2(3)) cors_top_i (.mclk, .rstn, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_pin_a, .mode_pin_b, .ext_int_pin_n,
        .cpu_addr, .vector_fetch, .stop_req, .stop_wake, .clock_slow, .adc_power_up,
        .adc_clock_source_select, .ext_int_req, .cpu_hold, .clock_fail_reset, .watchdog_tick,
        .sys_state, .periph_state, .decode);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic boot(input logic b, input logic a);
        @(posedge mclk);
        mode_pin_b <= b;
        mode_pin_a <= a;
        rstn <= 1'h0;
        repeat (3) @(posedge mclk);
        rstn <= 1'h1;
    endtask : boot

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 chk(exp, reg_rdata);
    endtask : rd

    task automatic step(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (watchdog_tick !== 1'h1 && n < 2000);
    endtask : step

    task automatic irq(input logic edge_mode);
        int n = 0;
        ext_int_pin_n <= 1'h0;
        repeat (8) begin
            @(posedge mclk);
            #1 n += ext_int_req;
        end
        if (edge_mode) chk(1, n);
        else chk(1'h1, ext_int_req);
        ext_int_pin_n <= 1'h1;
        repeat (4) @(posedge mclk);
    endtask : irq

    task automatic mon(input logic [7:0] opt, input logic exp);
        wr(OPT, opt);
        clock_slow <= 1'h1;
        repeat (3) @(posedge mclk);
        #1 chk(exp, clock_fail_reset);
        clock_slow <= 1'h0;
    endtask : mon

    task automatic vec(input logic vf, input logic [15:0] exp);
        @(posedge mclk);
        vector_fetch <= vf;
        cpu_addr <= 16'hFFFE;
        @(posedge mclk);
        vector_fetch <= 1'h0;
        #1 chk(exp, decode.eff_addr);
    endtask : vec

    task automatic stop(input int exp);
        int n = 0;
        @(posedge mclk);
        stop_req <= 1'h1;
        @(posedge mclk);
        stop_req <= 1'h0;
        stop_wake <= 1'h1;
        @(posedge mclk);
        stop_wake <= 1'h0;
        #1;
        while (cpu_hold === 1'h1 && n < 100) begin
            n++;
            @(posedge mclk);
            #1;
        end
        chk(exp, n);
    endtask : stop
    ////////////////////////////////////////////////////////////////
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            boot(m[1], m[0]);
            #1 chk(CORS_COMPARE_RESET, periph_state.compare_value);
            chk(16'h0, {periph_state.timer_count});
            chk(16'hC000, {periph_state.serial_status, periph_state.serial_control});
            chk(17'h10000, {periph_state.rw_out, periph_state.port_c_direction,
                periph_state.port_bf_out});
            chk(16'h0, {periph_state.timer_flags_masks, periph_state.periodic_pulse_ctl});
            repeat (4) @(posedge mclk);
            #1 chk(8'hE6, {sys_state.condition_flags_sxi, sys_state.priority_source_select});
            chk({m != 2'h3, m[1]}, {sys_state.rom_enable, sys_state.watchdog_enable});
            chk({!m[1], !m[1]}, {sys_state.fail_reset_disable, sys_state.internal_read_visibility});
            chk({m == 2'h0, !m[1], m[0]}, {sys_state.boot_rom_enable, sys_state.special_mode_flag,
                sys_state.mode_a_latched});
            chk(m[1] ? CORS_VEC_NORMAL : CORS_VEC_SPECIAL, sys_state.restart_vector);
            rd(OPT, CORS_OPT_RESET);
        end
    endtask : t_modes

    task automatic t_normal();
        boot(1'h1, 1'h0);
        wr(OPT, 8'hFF);
        rd(OPT, 8'hFB);
        chk(2'h3, {adc_power_up, adc_clock_source_select});
        irq(1'h1);
        wr(OPT, 8'h00);
        rd(OPT, 8'h33);
        vec(1'h1, 16'hFFFE);
        stop(8);
        boot(1'h1, 1'h0);
        repeat (64) @(posedge mclk);
        wr(OPT, 8'hFF);
        rd(OPT, 8'hD8);
        irq(1'h0);
        mon(8'h18, 1'h1);
        mon(8'h10, 1'h0);
    endtask : t_normal

    task automatic t_special();
        boot(1'h0, 1'h0);
        repeat (70) @(posedge mclk);
        wr(OPT, 8'hFF);
        rd(OPT, 8'hFB);
        wr(OPT, 8'h00);
        rd(OPT, 8'h00);
        rd(16'h1040, 8'h00);
        vec(1'h1, 16'hBFFE);
        vec(1'h0, 16'hFFFE);
        stop(0);
        mon(8'h08, 1'h0);
    endtask : t_special

    task automatic t_wdog();
        int n;
        for (int r = 0; r < 4; r++) begin
            boot(1'h1, 1'h0);
            wr(OPT, 8'h10 | 8'(r));
            repeat (3) step(n);
            chk(32'h1 << (3 + 2 * r), n);
        end
    endtask : t_wdog

    task automatic conclude();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    initial begin
        t_modes();
        t_normal();
        t_special();
        t_wdog();
        conclude();
    end

    // roughly nine times the expected run
    initial begin
        #200000;
        failures++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
